/* common/vrlmc_defs.svh */
// timing constants and widths for the ramp limit mode control
`ifndef VRLMC_DEFS_SVH
`define VRLMC_DEFS_SVH
`define VRLMC_CLK_PERIOD_NS 20
`define VRLMC_SHORT_RAMP_NS 1250
`define VRLMC_LONG_RAMP_NS 40000
`define VRLMC_SHORT_CYC (`VRLMC_SHORT_RAMP_NS / `VRLMC_CLK_PERIOD_NS)
`define VRLMC_LONG_CYC (`VRLMC_LONG_RAMP_NS / `VRLMC_CLK_PERIOD_NS)
`define VRLMC_QUICK_CYC 2
`define VRLMC_SLOW_SHIFT 1
`define VRLMC_RAMP_W 8
`define VRLMC_RATE_W 12
`define VRLMC_CNT_W 13
`define VRLMC_RAMP_MAX 8'hff
`endif

/* common/vrlmc_pkg.sv */
// types for the ramp limit mode control
package vrlmc_pkg;
  typedef enum logic [2:0] {
    VRLMC_AT_LOW = 3'b001,
    VRLMC_RISING = 3'b010,
    VRLMC_AT_HIGH = 3'b100
  } vrlmc_state_t;
  typedef enum logic {
    VRLMC_RAMP_MODE = 1'b0,
    VRLMC_CURVE_MODE = 1'b1
  } vrlmc_curve_t;
endpackage

/* rtl/vrlmc_core.sv */
// ramp timing, limit decode, overflow strobe and ramp/curve axis drive
// Summary of operation
// RL1: lower_limit_n low when ramp fully discharged
// RL2: upper_limit_n low when ramp fully charged
// RL3: both high in transit; never both low
// RL4: strobe is NAND of the two limits
// RL5: status logic clocks overflow bit from strobe
// RL6: converters flag beam outside programmable area
// RL7: out of range forces z output blanked
// RL8: zero rate word gives 1.25 us ramp
// RL9: larger rate word gives longer ramp
// RL10: all-ones rate word gives 40 us ramp
// RL11: normal speed times from rate word only
// RL12: quick move completes ramp almost immediately
// RL13: slow select stretches every ramp except a quick move
// RL14: curve mode code clears curve select
// RL15: start pulse trailing edge sets curve select
// RL16: ramp mode drives identical x and y
// RL17: curve mode drives cosine x, sine y
// RL18: direction high charges, low discharges ramp
// RL19: short vectors present all-zero rate word
// RL20: ramp progress is a cycle counter
// RL21: reset clears curve select and overflow bit
`include "vrlmc_defs.svh"
module vrlmc_core
  import vrlmc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // controller inputs
  input wire logic ramp_direction,
  input wire logic [11:0] charge_rate_word,
  input wire logic quick_move_n,
  input wire logic slow_speed_sel,
  input wire logic curve_mode_code,
  input wire logic draw_mode_code,
  input wire logic curve_start_pulse,
  input wire logic beam_unblank_req,
  // converter input
  input wire logic beam_out_of_range,
  // limit code and strobe
  output logic lower_limit_n,
  output logic upper_limit_n,
  output logic overflow_sample_strobe,
  output logic overflow_flag,
  // axis drives
  output logic [7:0] x_axis_drive,
  output logic [7:0] y_axis_drive,
  output logic curve_mode,
  output logic z_intensity_out
);
  localparam logic [12:0] SHORT_CYC = 13'(`VRLMC_SHORT_CYC);
  localparam logic [12:0] LONG_CYC = 13'(`VRLMC_LONG_CYC);
  localparam logic [12:0] QUICK_CYC = 13'(`VRLMC_QUICK_CYC);

  // quarter-wave sine, 16 points over the 8-bit ramp span
  function automatic logic [7:0] sine_q(input logic [7:0] r);
    logic [7:0] t;
    t = 8'h00;
    case (r[7:4])
      4'h0: t = 8'h00;
      4'h1: t = 8'h19;
      4'h2: t = 8'h32;
      4'h3: t = 8'h4a;
      4'h4: t = 8'h62;
      4'h5: t = 8'h78;
      4'h6: t = 8'h8e;
      4'h7: t = 8'ha2;
      4'h8: t = 8'hb5;
      4'h9: t = 8'hc6;
      4'ha: t = 8'hd5;
      4'hb: t = 8'he2;
      4'hc: t = 8'hed;
      4'hd: t = 8'hf5;
      4'he: t = 8'hfb;
      default: t = 8'hff;
    endcase
    return t;
  endfunction

  // synchronised inputs
  logic [1:0] dir_s_ff, qm_s_ff, slow_s_ff, cmc_s_ff, csp_s_ff, oor_s_ff, dmc_s_ff, ub_s_ff;
  logic [11:0] rate_a_ff, rate_b_ff;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      dir_s_ff <= 2'h0;
      qm_s_ff <= 2'h3;
      slow_s_ff <= 2'h0;
      cmc_s_ff <= 2'h0;
      csp_s_ff <= 2'h3;
      oor_s_ff <= 2'h0;
      dmc_s_ff <= 2'h0;
      ub_s_ff <= 2'h0;
      rate_a_ff <= 12'h000;
      rate_b_ff <= 12'h000;
    end
    else
    begin
      dir_s_ff <= {dir_s_ff[0], ramp_direction};
      qm_s_ff <= {qm_s_ff[0], quick_move_n};
      slow_s_ff <= {slow_s_ff[0], slow_speed_sel};
      cmc_s_ff <= {cmc_s_ff[0], curve_mode_code};
      csp_s_ff <= {csp_s_ff[0], curve_start_pulse};
      oor_s_ff <= {oor_s_ff[0], beam_out_of_range};
      dmc_s_ff <= {dmc_s_ff[0], draw_mode_code};
      ub_s_ff <= {ub_s_ff[0], beam_unblank_req};
      rate_a_ff <= charge_rate_word;
      rate_b_ff <= rate_a_ff;
    end
  end
  logic csp_d_ff;

  // ramp counter state
  vrlmc_state_t state_ff, nxt_state;
  logic [12:0] cnt_ff, nxt_cnt;
  logic [12:0] term;
  logic [7:0] ramp_lvl;
  logic [24:0] span;
  always_comb
  begin
    span = 25'(LONG_CYC - SHORT_CYC) * 25'(rate_b_ff);
    term = SHORT_CYC + 13'(span / 25'hfff); // RL8 RL9 RL10 RL11 RL19
    if (!qm_s_ff[1])
      term = QUICK_CYC; // RL12
    else if (slow_s_ff[1])
      term = 13'(term << `VRLMC_SLOW_SHIFT); // RL13
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      VRLMC_AT_LOW:
      begin
        nxt_cnt = 13'h0000;
        if (dir_s_ff[1])
          nxt_state = VRLMC_RISING; // RL18
      end
      VRLMC_RISING:
      begin
        if (dir_s_ff[1])
        begin
          if (cnt_ff >= term - 13'h0001)
            nxt_state = VRLMC_AT_HIGH; // RL20
          else
            nxt_cnt = cnt_ff + 13'h0001;
        end
        else if (cnt_ff == 13'h0000)
          nxt_state = VRLMC_AT_LOW;
        else
          nxt_cnt = cnt_ff - 13'h0001; // RL18
      end
      VRLMC_AT_HIGH:
      begin
        if (!dir_s_ff[1])
        begin
          nxt_state = VRLMC_RISING; // RL18
          nxt_cnt = term - 13'h0001; // RL9 RL10
        end
      end
      default:
      begin
        nxt_state = VRLMC_AT_LOW;
        nxt_cnt = 13'h0000;
      end
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_ff <= VRLMC_AT_LOW;
      cnt_ff <= 13'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // mode flip-flop and outputs
  vrlmc_curve_t mode_ff, nxt_mode;
  logic nxt_low_n, nxt_up_n, nxt_ovf;
  logic [7:0] nxt_x, nxt_y;
  logic [20:0] scaled;
  always_comb
  begin
    nxt_mode = mode_ff;
    if (cmc_s_ff[1])
      nxt_mode = VRLMC_RAMP_MODE; // RL14
    else if (csp_s_ff[1] && !csp_d_ff)
      nxt_mode = VRLMC_CURVE_MODE; // RL15
    nxt_low_n = (nxt_state != VRLMC_AT_LOW); // RL1
    nxt_up_n = (nxt_state != VRLMC_AT_HIGH); // RL2 RL3
    scaled = 21'(nxt_cnt) * 21'(`VRLMC_RAMP_MAX) / 21'(term == 13'h0000 ? 13'h0001 : term);
    if (nxt_state == VRLMC_AT_HIGH)
      ramp_lvl = `VRLMC_RAMP_MAX;
    else if (nxt_state == VRLMC_AT_LOW)
      ramp_lvl = 8'h00;
    else
      ramp_lvl = (scaled > 21'(`VRLMC_RAMP_MAX)) ? `VRLMC_RAMP_MAX : scaled[7:0];
    if (nxt_mode == VRLMC_CURVE_MODE)
    begin
      nxt_x = sine_q(8'(`VRLMC_RAMP_MAX - ramp_lvl)); // RL17
      nxt_y = sine_q(ramp_lvl); // RL17
    end
    else
    begin
      nxt_x = ramp_lvl; // RL16
      nxt_y = ramp_lvl; // RL16
    end
    nxt_ovf = overflow_flag;
    if (!overflow_sample_strobe && !(nxt_low_n && nxt_up_n))
      nxt_ovf = oor_s_ff[1]; // RL5 RL6
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mode_ff <= VRLMC_RAMP_MODE; // RL21
      csp_d_ff <= 1'b1;
      lower_limit_n <= 1'b0;
      upper_limit_n <= 1'b1;
      overflow_sample_strobe <= 1'b1;
      overflow_flag <= 1'b0; // RL21
      x_axis_drive <= 8'h00;
      y_axis_drive <= 8'h00;
      curve_mode <= 1'b0;
      z_intensity_out <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      csp_d_ff <= csp_s_ff[1];
      lower_limit_n <= nxt_low_n;
      upper_limit_n <= nxt_up_n;
      overflow_sample_strobe <= ~(nxt_low_n & nxt_up_n); // RL4
      overflow_flag <= nxt_ovf;
      x_axis_drive <= nxt_x;
      y_axis_drive <= nxt_y;
      curve_mode <= (nxt_mode == VRLMC_CURVE_MODE);
      z_intensity_out <= ub_s_ff[1] & dmc_s_ff[1] & ~oor_s_ff[1] & nxt_low_n & nxt_up_n; // RL7
    end
  end

  // checks
  never_both_low_a: assert property (@(posedge ref_clk) disable iff (reset) // RL3
    lower_limit_n || upper_limit_n) else $error("both limits low");
  strobe_nand_a: assert property (@(posedge ref_clk) disable iff (reset) // RL4
    overflow_sample_strobe == !(lower_limit_n && upper_limit_n)) else $error("strobe wrong");
  blank_oor_a: assert property (@(posedge ref_clk) disable iff (reset) // RL7
    oor_s_ff[1] |=> !z_intensity_out) else $error("z not blanked");
  curve_clear_a: assert property (@(posedge ref_clk) disable iff (reset) // RL14
    cmc_s_ff[1] |=> !curve_mode) else $error("curve not cleared");
  curve_set_a: assert property (@(posedge ref_clk) disable iff (reset) // RL15
    (!cmc_s_ff[1] && csp_s_ff[1] && !csp_d_ff) |=> curve_mode) else $error("curve not set");
  ramp_equal_a: assert property (@(posedge ref_clk) disable iff (reset) // RL16
    !curve_mode |-> x_axis_drive == y_axis_drive) else $error("axes differ");
  quick_done_a: assert property (@(posedge ref_clk) disable iff (reset) // RL12
    (state_ff == VRLMC_AT_LOW && dir_s_ff[1] && !qm_s_ff[1]) ##1 (dir_s_ff[1] && !qm_s_ff[1])[*3]
    |-> ##[0:1] !upper_limit_n) else $error("quick ramp slow");
  short_ramp_a: assert property (@(posedge ref_clk) disable iff (reset) // RL8
    (state_ff == VRLMC_RISING && cnt_ff == 13'h0000 && rate_b_ff == 12'h000
     && qm_s_ff[1] && !slow_s_ff[1] && dir_s_ff[1]) |-> term == SHORT_CYC)
    else $error("short ramp length wrong");
  rise_start_a: assert property (@(posedge ref_clk) disable iff (reset) // RL18
    (state_ff == VRLMC_AT_LOW && dir_s_ff[1]) |=> lower_limit_n) else $error("ramp not rising");
  // limit decode, timing, axis, mode hold and reset checks
  lower_decode_a: assert property (@(posedge ref_clk) disable iff (reset) // RL1
    (state_ff == VRLMC_AT_LOW) == !lower_limit_n)
    else $error("lower limit decode wrong");
  upper_decode_a: assert property (@(posedge ref_clk) disable iff (reset) // RL2
    (state_ff == VRLMC_AT_HIGH) == !upper_limit_n)
    else $error("upper limit decode wrong");
  transit_high_a: assert property (@(posedge ref_clk) disable iff (reset) // RL3
    (state_ff == VRLMC_RISING) |-> (lower_limit_n && upper_limit_n))
    else $error("transit code wrong");
  hold_low_a: assert property (@(posedge ref_clk) disable iff (reset) // RL18
    (state_ff == VRLMC_AT_LOW && !dir_s_ff[1]) |=> !lower_limit_n)
    else $error("left lower limit");
  hold_high_a: assert property (@(posedge ref_clk) disable iff (reset) // RL18
    (state_ff == VRLMC_AT_HIGH && dir_s_ff[1]) |=> !upper_limit_n)
    else $error("left upper limit");
  fall_start_a: assert property (@(posedge ref_clk) disable iff (reset) // RL18
    (state_ff == VRLMC_AT_HIGH && !dir_s_ff[1]) |=> upper_limit_n)
    else $error("ramp not falling");
  long_term_a: assert property (@(posedge ref_clk) disable iff (reset) // RL10
    (rate_b_ff == 12'hfff && qm_s_ff[1] && !slow_s_ff[1]) |-> (term == LONG_CYC))
    else $error("long ramp length wrong");
  slow_term_a: assert property (@(posedge ref_clk) disable iff (reset) // RL13
    (qm_s_ff[1] && slow_s_ff[1]) |-> (term >= 13'(SHORT_CYC << 1)))
    else $error("slow ramp not stretched");
  axis_top_a: assert property (@(posedge ref_clk) disable iff (reset) // RL16
    (!curve_mode && !upper_limit_n) |-> (x_axis_drive == 8'hff))
    else $error("ramp top level wrong");
  axis_bottom_a: assert property (@(posedge ref_clk) disable iff (reset) // RL16
    (!curve_mode && !lower_limit_n) |-> (x_axis_drive == 8'h00))
    else $error("ramp bottom level wrong");
  curve_top_a: assert property (@(posedge ref_clk) disable iff (reset) // RL17
    (curve_mode && !upper_limit_n) |-> (x_axis_drive == 8'h00 && y_axis_drive == 8'hff))
    else $error("curve end point wrong");
  curve_bottom_a: assert property (@(posedge ref_clk) disable iff (reset) // RL17
    (curve_mode && !lower_limit_n) |-> (x_axis_drive == 8'hff && y_axis_drive == 8'h00))
    else $error("curve start point wrong");
  mode_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // RL15
    (!cmc_s_ff[1] && !(csp_s_ff[1] && !csp_d_ff)) |=> $stable(curve_mode))
    else $error("curve select changed");
  reset_clear_a: assert property (@(posedge ref_clk) // RL21
    reset |=> (!curve_mode && !overflow_flag))
    else $error("reset left state set");
endmodule

/* bench/vrlmc_partner.sv */
// controller and converter stand-in: start pulse and out-of-range flag
module vrlmc_partner
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bench commands
  input wire logic start_req,
  input wire logic range_err,
  // device inputs
  output logic curve_start_pulse,
  output logic beam_out_of_range
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] low_cnt_ff;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      low_cnt_ff <= 2'h0;
    else if (start_req)
      low_cnt_ff <= 2'h2;
    else if (low_cnt_ff != 2'h0)
      low_cnt_ff <= low_cnt_ff - 2'h1;
  end
  assign curve_start_pulse = (low_cnt_ff == 2'h0);
  assign beam_out_of_range = range_err;
endmodule

/* bench/vector_ramp_limit_mode_control_tb_top.sv */
// bench for the ramp limit mode control
module vector_ramp_limit_mode_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, reset = 1'b1, dir = 1'b0, quick_n = 1'b1, slow = 1'b0;
  logic code = 1'b0, start_req = 1'b0, range_err = 1'b0;
  logic draw = 1'b1, unblank = 1'b1;
  logic [11:0] rate = 12'h000;
  logic start_n, oor, lo_n, up_n, strobe, flag, cmode, z;
  logic [7:0] x, y;
  int fails = 0, compares = 0;
  vrlmc_core dut (.ref_clk(ref_clk), .reset(reset), .ramp_direction(dir),
    .charge_rate_word(rate), .quick_move_n(quick_n), .slow_speed_sel(slow),
    .curve_mode_code(code), .draw_mode_code(draw), .curve_start_pulse(start_n),
    .beam_unblank_req(unblank), .beam_out_of_range(oor), .lower_limit_n(lo_n),
    .upper_limit_n(up_n), .overflow_sample_strobe(strobe), .overflow_flag(flag),
    .x_axis_drive(x), .y_axis_drive(y), .curve_mode(cmode), .z_intensity_out(z));
  vrlmc_partner peer (.ref_clk(ref_clk), .reset(reset), .start_req(start_req),
    .range_err(range_err),
    .curve_start_pulse(start_n), .beam_out_of_range(oor));
  task automatic summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_v(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_t(input int got, input int exp);
    compares++;
    if (got < exp - 2 || got > exp + 2)
    begin
      fails++;
      $display("ERROR %0t ramp took %0d expected %0d", $time, got, exp);
    end
  endtask
  function automatic int term(input int r, input logic qn, input logic sl);
    int t;
    t = qn ? 62 + (1938 * r) / 4095 : 2;
    return sl ? 2 * t : t;
  endfunction
  task automatic wait_lvl(input logic sel, input logic lvl, output int n);
    n = 0;
    while ((sel ? up_n : lo_n) !== lvl)
    begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 9000)
      begin
        fails++;
        $display("ERROR %0t limit wait ran out", $time);
        summarize();
      end
    end
  endtask
  task automatic ramp(input logic up, input logic [11:0] r, input logic qn,
    input logic sl, input logic re, input logic cm);
    int n;
    @(posedge ref_clk);
    rate <= r;
    quick_n <= qn;
    slow <= sl;
    range_err <= re;
    draw <= re | 1'($urandom);
    unblank <= re | 1'($urandom);
    repeat (3) @(posedge ref_clk);
    dir <= up;
    wait_lvl(!up, 1'b1, n);
    check_v({6'h0, up_n, lo_n}, 8'h03);
    check_v({7'h0, strobe}, 8'h00);
    check_v({7'h0, z}, {7'h0, !re && draw && unblank});
    wait_lvl(up, 1'b0, n);
    check_t(n, term(r, qn, sl));
    check_v({6'h0, up_n, lo_n}, up ? 8'h01 : 8'h02);
    check_v({7'h0, strobe}, 8'h01);
    check_v({7'h0, flag}, {7'h0, re});
    check_v(y, up ? 8'hff : 8'h00);
    check_v(x, (up ^ cm) ? 8'hff : 8'h00);
  endtask
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  initial
  begin
    void'($urandom(41));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    check_v({3'h0, cmode, flag, strobe, up_n, lo_n}, 8'h06);
    ramp(1'b1, 12'h000, 1'b1, 1'b0, 1'b0, 1'b0);
    ramp(1'b0, 12'hfff, 1'b1, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      ramp(1'b1, 12'($urandom), 1'b1, 1'b0, 1'b0, 1'b0);
      ramp(1'b0, 12'($urandom), 1'b1, 1'b1, 1'b0, 1'b0);
    end
    ramp(1'b1, 12'hfff, 1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge ref_clk);
    code <= 1'b1;
    @(posedge ref_clk);
    code <= 1'b0;
    repeat (3) @(posedge ref_clk);
    start_req <= 1'b1;
    @(posedge ref_clk);
    start_req <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    check_v({7'h0, cmode}, 8'h01);
    ramp(1'b0, 12'h000, 1'b1, 1'b0, 1'b0, 1'b1);
    ramp(1'b1, 12'h000, 1'b1, 1'b0, 1'b0, 1'b1);
    @(posedge ref_clk);
    code <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    check_v({7'h0, cmode}, 8'h00);
    summarize();
  end
endmodule
